/* hw/lid_pkg.sv */
// package for the link instruction decoder
package lid_pkg;
   // ****************
   // timing
   // ****************
   localparam int CLK_PERIOD_NS = 10;
   localparam int MS_NS = 1000000;
   localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
   // ****************
   // register offsets
   // ****************
   localparam logic [7:0] ADDR_REQ = 8'h00;
   localparam logic [7:0] ADDR_REPLY = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
   localparam logic [7:0] ADDR_CONFIG = 8'h10;
   localparam logic [7:0] ADDR_STATE = 8'h14;
   // ****************
   // fields and resets
   // ****************
   localparam int REQ_W = 25;
   localparam int CFG_SPD_BIT = 16;
   localparam int CFG_EXT01_BIT = 17;
   localparam int CFG_DISP100_BIT = 18;
   localparam int RUN_FWD_BIT = 1;
   localparam int RUN_REV_BIT = 2;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_ERR_BIT = 1;
   localparam int IRQ_TMO_BIT = 2;
   localparam logic [31:0] CFG_RST = 32'h0000_0000;
   localparam logic [7:0] SSEL_RST = 8'h01;
   localparam logic [1:0] MODE_RST = 2'h1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ****************
   // instruction codes and data
   // ****************
   localparam logic [7:0] C_MODE_RD = 8'h7b;
   localparam logic [7:0] C_MODE_WR = 8'hfb;
   localparam logic [7:0] C_FREQ = 8'h6f;
   localparam logic [7:0] C_CUR = 8'h70;
   localparam logic [7:0] C_VOLT = 8'h71;
   localparam logic [7:0] C_SPEC = 8'h72;
   localparam logic [7:0] C_SSEL_RD = 8'h73;
   localparam logic [7:0] C_SSEL_WR = 8'hf3;
   localparam logic [7:0] C_FH_FIRST = 8'h74;
   localparam logic [7:0] C_FH_LAST = 8'h77;
   localparam logic [7:0] C_RUNX = 8'hf9;
   localparam logic [7:0] C_RUN = 8'hfa;
   localparam logic [7:0] C_STATX = 8'h79;
   localparam logic [7:0] C_STAT = 8'h7a;
   localparam logic [15:0] MODE_MAX = 16'h0002;
   localparam logic [15:0] SSEL_MIN = 16'h0001;
   localparam logic [15:0] SSEL_MAX = 16'h0040;
   // ****************
   // carriers
   // ****************
   typedef struct packed {
      logic bad;
      logic [7:0] code;
      logic [15:0] data;
   } lid_req_s;
   typedef struct packed {
      logic err;
      logic six;
      logic [23:0] data;
   } lid_rep_s;
endpackage

/* hw/lid_link_decoder.sv */
// link instruction decoder with axi4-lite register access
`timescale 1ns/10ps
// Summary of operation
// (RULE_01) one exchange per host request, never unprompted
// (RULE_02) silent link past interval: alarm stop
// (RULE_03) coast stop input forces coasting stop
// (RULE_04) host sets check interval before running
// (RULE_05) host finishes link setup before commands
// (RULE_06) mode read 7b, write fb, 0..2
// (RULE_07) 6f returns output frequency, 0.01 hz
// (RULE_08) fine speed setting gives six-digit frequency
// (RULE_09) display select 100: stopped shows set frequency; with fine speed setting 6f returns mon_fine_freq instead
// (RULE_10) 70 returns output current, 0.01 a
// (RULE_11) 71 returns output voltage, 0.1 v
// (RULE_12) 72 returns selected special monitor value
// (RULE_13) selection read 73, write f3, 01..40
// (RULE_14) 74..77 give fault pairs, newer low
// (RULE_15) f9/fa set run command inputs
// (RULE_16) 79/7a return drive output status
// (RULE_17) request with data error is rejected
// (RULE_18) characters: start, 7/8 data, parity, stops; the decoder takes only a data error flag, request bit 24
// (RULE_19) unknown code gets error, nothing changes
module lid_link_decoder
   import lid_pkg::*;
#(
   parameter int MS_TICKS = MS_CYCLES
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [15:0] mon_out_freq,
   input wire logic [15:0] mon_set_freq,
   input wire logic [23:0] mon_fine_freq,
   input wire logic [15:0] mon_current,
   input wire logic [15:0] mon_voltage,
   input wire logic [23:0] mon_special,
   input wire logic [63:0] fault_hist,
   input wire logic [15:0] drive_status,
   input wire logic drive_running,
   input wire logic coast_stop_input,
   output logic irq,
   output logic forward_run_input,
   output logic reverse_run_input,
   output logic [15:0] run_cmd,
   output logic [1:0] op_mode,
   output logic [7:0] special_sel,
   output logic link_timeout_alarm,
   output logic motor_enable
);
   localparam int MSW = $clog2(MS_TICKS + 1);
   logic coast_meta, coast_sync, req_go;
   logic [31:0] req_word, cfg;
   logic [2:0] irq_stat, irq_mask;
   logic [MSW-1:0] ms_cnt;
   logic [15:0] ivl_cnt;
   lid_rep_s rep, next_rep;
   lid_req_s rq;
   logic do_mode, do_ssel, do_runx, do_run, known;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
      for (int i = 0; i < 4; i++)
      begin
         if (st[i])
            old[8*i +: 8] = nw[8*i +: 8];
      end
      return old;
   endfunction

   // ****************
   // coast stop synchroniser
   // ****************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         coast_meta <= 1'b0;
         coast_sync <= 1'b0;
      end
      else
      begin
         coast_meta <= coast_stop_input;
         coast_sync <= coast_meta;
      end
   end

   // ****************
   // axi4-lite slave
   // ****************
   wire next_wacc = ~awready & awvalid & wvalid & ~bvalid;
   wire wr_go = awready & awvalid & wvalid;
   wire wr_req = awaddr == ADDR_REQ;
   wire wr_mask = awaddr == ADDR_IRQ_MASK;
   wire wr_cfg = awaddr == ADDR_CONFIG;
   wire wr_hit = wr_req | wr_mask | wr_cfg;
   wire next_racc = ~arready & arvalid & ~rvalid;
   wire rd_go = arready & arvalid;
   wire rd_stat = araddr == ADDR_IRQ_STAT;
   wire rd_hit = araddr == ADDR_REQ || araddr == ADDR_REPLY || rd_stat || araddr == ADDR_IRQ_MASK
                 || araddr == ADDR_CONFIG || araddr == ADDR_STATE;
   wire [31:0] state_word = {4'h0, coast_sync, link_timeout_alarm, special_sel, op_mode, run_cmd};
   wire [31:0] rd_mux = araddr == ADDR_REQ ? req_word :
                        araddr == ADDR_REPLY ? {6'h0, rep} :
                        rd_stat ? {29'h0, irq_stat} :
                        araddr == ADDR_IRQ_MASK ? {29'h0, irq_mask} :
                        araddr == ADDR_CONFIG ? cfg :
                        araddr == ADDR_STATE ? state_word : 32'h0;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         arready <= 1'b0;
         rvalid <= 1'b0;
         rresp <= RESP_OKAY;
         rdata <= 32'h0;
      end
      else
      begin
         awready <= next_wacc;
         wready <= next_wacc;
         if (wr_go)
            bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         bvalid <= wr_go | (bvalid & ~bready);
         arready <= next_racc;
         if (rd_go)
         begin
            rdata <= rd_mux;
            rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end
         rvalid <= rd_go | (rvalid & ~rready);
      end
   end

   // ****************
   // writable registers
   // ****************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         req_word <= 32'h0;
         cfg <= CFG_RST;
         irq_mask <= 3'h0;
         req_go <= 1'b0;
      end
      else
      begin
         if (wr_go & wr_req)
            req_word <= merge(req_word, wdata, wstrb);
         if (wr_go & wr_cfg)
            cfg <= merge(cfg, wdata, wstrb);
         if (wr_go & wr_mask & wstrb[0])
            irq_mask <= wdata[2:0];
         req_go <= wr_go & wr_req; // see RULE_01
      end
   end

   // ****************
   // instruction decode
   // ****************
   assign rq = lid_req_s'(req_word[REQ_W-1:0]); // see RULE_18
   wire is_fh = rq.code >= C_FH_FIRST && rq.code <= C_FH_LAST;
   wire [15:0] fh_word = fault_hist[16*rq.code[1:0] +: 16]; // see RULE_14
   wire fine = cfg[CFG_SPD_BIT] & cfg[CFG_EXT01_BIT];
   wire stop_view = cfg[CFG_DISP100_BIT] & ~drive_running;
   wire [15:0] freq4 = stop_view ? mon_set_freq : mon_out_freq; // see RULE_09
   wire mode_ok = rq.data <= MODE_MAX;
   wire ssel_ok = rq.data >= SSEL_MIN && rq.data <= SSEL_MAX;

   always_comb
   begin
      next_rep = '0;
      do_mode = 1'b0;
      do_ssel = 1'b0;
      do_runx = 1'b0;
      do_run = 1'b0;
      known = 1'b1;
      case (rq.code)
         C_MODE_RD: next_rep.data = {22'h0, op_mode}; // see RULE_06
         C_MODE_WR:
         begin
            do_mode = mode_ok; // see RULE_06
            next_rep.err = ~mode_ok;
         end
         C_FREQ:
         begin
            next_rep.six = fine; // see RULE_08
            next_rep.data = fine ? mon_fine_freq : {8'h0, freq4}; // see RULE_07
         end
         C_CUR: next_rep.data = {8'h0, mon_current}; // see RULE_10
         C_VOLT: next_rep.data = {8'h0, mon_voltage}; // see RULE_11
         C_SPEC:
         begin
            next_rep.six = fine;
            next_rep.data = fine ? mon_special : {8'h0, mon_special[15:0]}; // see RULE_12
         end
         C_SSEL_RD: next_rep.data = {16'h0, special_sel}; // see RULE_13
         C_SSEL_WR:
         begin
            do_ssel = ssel_ok; // see RULE_13
            next_rep.err = ~ssel_ok;
         end
         C_RUNX: do_runx = 1'b1; // see RULE_15
         C_RUN: do_run = 1'b1; // see RULE_15
         C_STATX: next_rep.data = {8'h0, drive_status}; // see RULE_16
         C_STAT: next_rep.data = {16'h0, drive_status[7:0]}; // see RULE_16
         default:
         begin
            known = is_fh;
            next_rep.data = {8'h0, fh_word};
            if (!is_fh)
            begin
               next_rep = '0;
               next_rep.err = 1'b1; // see RULE_19
            end
         end
      endcase
      if (rq.bad)
      begin
         next_rep = '0;
         next_rep.err = 1'b1; // see RULE_17
         do_mode = 1'b0;
         do_ssel = 1'b0;
         do_runx = 1'b0;
         do_run = 1'b0;
      end
   end

   // ****************
   // link watchdog and stop control
   // ****************
   wire ms_tick = ms_cnt == MSW'(MS_TICKS - 1);
   wire link_ok = req_go & ~rq.bad;
   wire timeout_hit = cfg[15:0] != 16'h0 && ivl_cnt >= cfg[15:0] && ~link_timeout_alarm; // see RULE_02
   wire stop_all = coast_sync | timeout_hit | link_timeout_alarm; // see RULE_03
   wire [15:0] next_run = stop_all ? 16'h0 :
                          req_go & do_runx ? rq.data :
                          req_go & do_run ? {8'h0, rq.data[7:0]} : run_cmd; // see RULE_15
   wire [2:0] irq_ev = {timeout_hit, req_go & next_rep.err, req_go};
   wire [2:0] next_stat = (rd_go & rd_stat ? 3'h0 : irq_stat) | irq_ev;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ms_cnt <= '0;
         ivl_cnt <= 16'h0;
         link_timeout_alarm <= 1'b0;
         motor_enable <= 1'b0;
         run_cmd <= 16'h0;
         forward_run_input <= 1'b0;
         reverse_run_input <= 1'b0;
         irq_stat <= 3'h0;
         irq <= 1'b0;
      end
      else
      begin
         ms_cnt <= ms_tick ? '0 : ms_cnt + 1'b1;
         if (link_ok | coast_sync | (cfg[15:0] == 16'h0))
            ivl_cnt <= 16'h0;
         else if (ms_tick && ivl_cnt != 16'hffff)
            ivl_cnt <= ivl_cnt + 16'h1;
         link_timeout_alarm <= ~coast_sync & (link_timeout_alarm | timeout_hit); // see RULE_02
         motor_enable <= ~stop_all; // see RULE_03
         run_cmd <= next_run;
         forward_run_input <= next_run[RUN_FWD_BIT];
         reverse_run_input <= next_run[RUN_REV_BIT];
         irq_stat <= next_stat;
         irq <= |(next_stat & irq_mask);
      end
   end

   // ****************
   // reply and settings
   // ****************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rep <= '0;
         op_mode <= MODE_RST;
         special_sel <= SSEL_RST;
      end
      else if (req_go)
      begin
         rep <= next_rep; // see RULE_01
         if (do_mode)
            op_mode <= rq.data[1:0];
         if (do_ssel)
            special_sel <= rq.data[7:0];
      end
   end

   // ****************
   // checks
   // ****************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_req(logic [7:0] c);
      req_go && rq.code == c && !rq.bad;
   endsequence

   chk_one_exchange: assert property ($rose(irq_stat[IRQ_DONE_BIT]) |-> $past(req_go)) // see RULE_01
      else $error("done flag without request");
   chk_timeout_stop: assert property (timeout_hit && !coast_sync |=> link_timeout_alarm && !motor_enable ##1 run_cmd == 16'h0) // see RULE_02
      else $error("timeout did not stop drive");
   chk_coast_stop: assert property (coast_sync |=> !motor_enable && !forward_run_input && !reverse_run_input) // see RULE_03
      else $error("coast stop ignored");
   chk_mode_write: assert property (s_req(C_MODE_WR) ##0 mode_ok |=> op_mode == $past(rq.data[1:0])) // see RULE_06
      else $error("mode write lost");
   chk_fine_format: assert property (s_req(C_FREQ) |=> rep.six == $past(fine)) // see RULE_08
      else $error("frequency format wrong");
   chk_stop_view: assert property (s_req(C_FREQ) ##0 (!fine && stop_view) |=> rep.data[15:0] == $past(mon_set_freq)) // see RULE_09
      else $error("stopped frequency view wrong");
   chk_ssel_range: assert property (special_sel >= SSEL_MIN[7:0] && special_sel <= SSEL_MAX[7:0]) // see RULE_13
      else $error("selection out of range");
   chk_fault_pair: assert property (req_go && is_fh && !rq.bad |=> rep.data[15:0] == $past(fh_word)) // see RULE_14
      else $error("fault pair wrong");
   chk_bad_frame: assert property (req_go && rq.bad |=> rep.err && $stable(op_mode) && $stable(special_sel)) // see RULE_17
      else $error("bad frame acted on");
   chk_unknown_code: assert property (req_go && !known |=> rep.err && ($stable(run_cmd) || run_cmd == 16'h0) && $stable(op_mode)) // see RULE_19
      else $error("unknown code accepted");
endmodule // lid_link_decoder

/* test/lid_drive_model.sv */
// drive-side model feeding monitors, status and fault history
`timescale 1ns/10ps
module lid_drive_model
   import lid_pkg::*;
(
   input wire logic forward_run_input,
   input wire logic reverse_run_input,
   input wire logic [7:0] special_sel,
   output logic [15:0] mon_out_freq,
   output logic [15:0] mon_set_freq,
   output logic [23:0] mon_fine_freq,
   output logic [15:0] mon_current,
   output logic [15:0] mon_voltage,
   output logic [23:0] mon_special,
   output logic [63:0] fault_hist,
   output logic [15:0] drive_status,
   output logic drive_running
);
   // ****************
   // monitor values
   // ****************
   assign drive_running = forward_run_input | reverse_run_input;
   assign mon_out_freq = 16'h1388;
   assign mon_set_freq = 16'h0bb8;
   assign mon_fine_freq = 24'h0a1b2c;
   assign mon_current = 16'h0321;
   assign mon_voltage = 16'h0e4d;
   assign mon_special = {8'h00, special_sel, 8'h3c};
   assign fault_hist = 64'h8877_6655_4433_2211;
   assign drive_status = {13'h0, drive_running, reverse_run_input, forward_run_input};
endmodule // lid_drive_model

/* test/lid_link_decoder_tb.sv */
// self-checking bench for the link instruction decoder
`timescale 1ns/10ps
module lid_link_decoder_tb;
   import lid_pkg::*;
   localparam logic [31:0] E = 32'h0200_0000;
   localparam logic [31:0] A = 32'hffff_ffff;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [7:0] awaddr, araddr, special_sel;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, op_mode;
   logic [15:0] mon_out_freq, mon_set_freq, mon_current, mon_voltage, drive_status, run_cmd;
   logic [23:0] mon_fine_freq, mon_special;
   logic [63:0] fault_hist;
   logic drive_running, coast_stop_input, irq, forward_run_input, reverse_run_input;
   logic link_timeout_alarm, motor_enable;
   int bad_count = 0;
   int checked = 0;
   lid_link_decoder #(.MS_TICKS(10)) lid_link_decoder_inst (.*);
   lid_drive_model lid_drive_model_inst (.*);
   // ****************
   // tasks
   // ****************
   task automatic report_and_stop;
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic ck(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic ckb(input logic got, input logic exp);
      ck({31'h0, got}, {31'h0, exp});
   endtask
   task automatic tmo;
      bad_count++;
      $display("mismatch at %0t: no answer", $time);
      report_and_stop();
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      @(posedge aclk);
      while (!(awready === 1'b1 && wready === 1'b1))
      begin
         if (++n > 50) tmo();
         @(posedge aclk);
      end
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      @(posedge aclk);
      while (bvalid !== 1'b1)
      begin
         if (++n > 50) tmo();
         @(posedge aclk);
      end
      bready <= 1'b0;
      ck({30'h0, bresp}, {30'h0, er});
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      @(posedge aclk);
      while (arready !== 1'b1)
      begin
         if (++n > 50) tmo();
         @(posedge aclk);
      end
      arvalid <= 1'b0;
      @(posedge aclk);
      while (rvalid !== 1'b1)
      begin
         if (++n > 50) tmo();
         @(posedge aclk);
      end
      d = rdata;
      rready <= 1'b0;
      ck({30'h0, rresp}, {30'h0, er});
      @(posedge aclk);
   endtask
   task automatic xe(input logic [7:0] c, input logic [15:0] d, input logic bad, input logic [31:0] exp,
      input logic [31:0] m);
      logic [31:0] rep;
      wr(ADDR_REQ, {7'h0, bad, c, d}, RESP_OKAY);
      rd(ADDR_REPLY, rep, RESP_OKAY);
      ck(rep & m, exp);
   endtask
   // ****************
   // clock and sequence
   // ****************
   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   initial
   begin
      logic [31:0] v;
      int i;
      {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
      wstrb = 4'hf;
      coast_stop_input = 1'b0;
      aresetn = 1'b0;
      idle(10);
      aresetn <= 1'b1;
      idle(1);
      rd(ADDR_STATE, v, RESP_OKAY);
      ck(v, 32'h0005_0000);
      ckb(motor_enable, 1'b1);
      wr(ADDR_CONFIG, 32'h0, RESP_OKAY);
      for (i = 0; i < 3; i++)
      begin
         xe(C_MODE_WR, 16'(i), 1'b0, 32'h0, E);
         xe(C_MODE_RD, 16'h0, 1'b0, 32'(i), A);
      end
      xe(C_MODE_WR, 16'h3, 1'b0, E, E);
      xe(C_MODE_WR, 16'h0, 1'b1, E, E);
      xe(8'h55, 16'h0, 1'b0, E, E);
      xe(C_MODE_RD, 16'h0, 1'b0, 32'h2, A);
      ck({30'h0, op_mode}, 32'h2);
      xe(C_FREQ, 16'h0, 1'b0, {16'h0, mon_out_freq}, A);
      xe(C_CUR, 16'h0, 1'b0, {16'h0, mon_current}, A);
      xe(C_VOLT, 16'h0, 1'b0, {16'h0, mon_voltage}, A);
      xe(C_SSEL_WR, 16'h40, 1'b0, 32'h0, E);
      xe(C_SSEL_WR, 16'h41, 1'b0, E, E);
      xe(C_SSEL_WR, 16'h0, 1'b0, E, E);
      xe(C_SSEL_RD, 16'h0, 1'b0, 32'h40, A);
      ck({24'h0, special_sel}, 32'h40);
      xe(C_SPEC, 16'h0, 1'b0, {8'h0, mon_special}, A);
      for (i = 0; i < 4; i++)
         xe(C_FH_FIRST + 8'(i), 16'h0, 1'b0, {16'h0, fault_hist[16*i +: 16]}, A);
      xe(C_RUN, 16'hff02, 1'b0, 32'h0, E);
      ck({14'h0, run_cmd, reverse_run_input, forward_run_input}, 32'h9);
      xe(C_STATX, 16'h0, 1'b0, {16'h0, drive_status}, A);
      wr(ADDR_CONFIG, 32'h0004_0000, RESP_OKAY);
      xe(C_FREQ, 16'h0, 1'b0, {16'h0, mon_out_freq}, A);
      xe(C_RUNX, 16'h0104, 1'b0, 32'h0, E);
      ck({14'h0, run_cmd, reverse_run_input, forward_run_input}, 32'h412);
      xe(C_STAT, 16'h0, 1'b0, {24'h0, drive_status[7:0]}, A);
      xe(C_RUNX, 16'h0, 1'b0, 32'h0, E);
      xe(C_FREQ, 16'h0, 1'b0, {16'h0, mon_set_freq}, A);
      wr(ADDR_CONFIG, 32'h0003_0000, RESP_OKAY);
      xe(C_FREQ, 16'h0, 1'b0, {8'h01, mon_fine_freq}, A);
      xe(C_SPEC, 16'h0, 1'b0, {8'h01, mon_special}, A);
      rd(ADDR_IRQ_STAT, v, RESP_OKAY);
      idle(20);
      rd(ADDR_IRQ_STAT, v, RESP_OKAY);
      ck(v, 32'h0);
      wr(ADDR_IRQ_MASK, 32'h2, RESP_OKAY);
      xe(C_CUR, 16'h0, 1'b0, {16'h0, mon_current}, A);
      idle(2);
      ckb(irq, 1'b0);
      xe(8'hc5, 16'h0, 1'b0, E, E);
      idle(2);
      ckb(irq, 1'b1);
      rd(ADDR_IRQ_STAT, v, RESP_OKAY);
      ck(v, 32'h3);
      idle(2);
      ckb(irq, 1'b0);
      rd(ADDR_IRQ_MASK, v, RESP_OKAY);
      ck(v, 32'h2);
      wstrb <= 4'he;
      wr(ADDR_IRQ_MASK, 32'h0, RESP_OKAY);
      wstrb <= 4'hf;
      rd(ADDR_IRQ_MASK, v, RESP_OKAY);
      ck(v, 32'h2);
      rd(8'h20, v, RESP_SLVERR);
      ck(v, 32'h0);
      wr(ADDR_REPLY, 32'h0, RESP_SLVERR);
      wr(ADDR_CONFIG, 32'h2, RESP_OKAY);
      xe(C_RUN, 16'h02, 1'b0, 32'h0, E);
      ckb(forward_run_input, 1'b1);
      idle(40);
      ckb(link_timeout_alarm, 1'b1);
      ckb(motor_enable, 1'b0);
      ckb(forward_run_input, 1'b0);
      rd(ADDR_IRQ_STAT, v, RESP_OKAY);
      ck(v & 32'h4, 32'h4);
      wr(ADDR_CONFIG, 32'h0, RESP_OKAY);
      coast_stop_input <= 1'b1;
      idle(5);
      xe(C_RUN, 16'h02, 1'b0, 32'h0, E);
      ckb(forward_run_input, 1'b0);
      ckb(motor_enable, 1'b0);
      ckb(link_timeout_alarm, 1'b0);
      coast_stop_input <= 1'b0;
      idle(5);
      ckb(motor_enable, 1'b1);
      report_and_stop();
   end
endmodule // lid_link_decoder_tb
